// File: hdl/spc_consts.svh
// Constants for the serial peripheral block
`ifndef SPC_CONSTS_SVH
`define SPC_CONSTS_SVH

`define SPC_OFF_CTRL   8'h10
`define SPC_OFF_STAT   8'h11
`define SPC_OFF_DATA   8'h12

`define SPC_CTRL_RST   8'h28
`define SPC_CTRL_WMASK 8'hbf
`define SPC_STAT_WMASK 8'h47

`define SPC_ST_ERRIE   6
`define SPC_ST_MODE_FAULT_DETECT_ENABLE  2

`define SPC_HALF_BD0   6'h01
`define SPC_HALF_BD1   6'h04
`define SPC_HALF_BD2   6'h10
`define SPC_HALF_BD3   6'h40

`define SPC_LAST_BIT   3'h7
`define SPC_LAST_HALF  4'hf

`endif

// File: hdl/spc_pkg.sv
// Types for the serial peripheral block
package spc_pkg;

  typedef struct packed {
    logic receive_irq_enable;
    logic rsvd;
    logic mstr;
    logic clock_polarity;
    logic clock_phase;
    logic wom;
    logic module_enable;
    logic transmit_irq_enable;
  } spc_ctrl_t;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss_n;
  } spc_pins_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_XFER = 2'b10
  } spc_state_t;

endpackage

// File: hdl/spc_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module spc_sync #(
  parameter int W = 4
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

// File: hdl/spc_baud.sv
// Master half-period tick generator
`include "spc_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module spc_baud (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [1:0] sel,
  output var  logic       tick
);
  logic [5:0] cnt_q;
  logic [5:0] lim;

  assign lim = (sel == 2'h0) ? `SPC_HALF_BD0 :
               (sel == 2'h1) ? `SPC_HALF_BD1 :
               (sel == 2'h2) ? `SPC_HALF_BD2 : `SPC_HALF_BD3;
  assign tick = run && (cnt_q == lim - 6'h01);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= 6'h00;
    end else if (!run || tick) begin
      cnt_q <= 6'h00;
    end else begin
      cnt_q <= cnt_q + 6'h01;
    end
  end
endmodule
`default_nettype wire

// File: hdl/spc_core.sv
// Serial peripheral block: registers, shifter, pin control
//
// The strobed register port was decided locally.
`include "spc_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module spc_core (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output var  logic [7:0] rdata,
  input  wire logic       sck_i,
  output var  logic       sck_o,
  output var  logic       sck_oe,
  input  wire logic       mosi_i,
  output var  logic       mosi_o,
  output var  logic       mosi_oe,
  input  wire logic       miso_i,
  output var  logic       miso_o,
  output var  logic       miso_oe,
  input  wire logic       ss_n_i,
  output var  logic       pins_owned,
  output var  logic       ss_input_only,
  output var  logic       ss_level,
  output var  logic       rx_irq,
  output var  logic       tx_irq
);

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  function automatic logic [1:0] pad(input logic drv, input logic val,
                                     input logic wom);
    pad = {drv && (!wom || !val), val && !wom};
  endfunction

  // ****************************************
  // State
  // ****************************************
  spc_pkg::spc_ctrl_t  ctrl_q;
  spc_pkg::spc_ctrl_t  ctrl_d;
  spc_pkg::spc_state_t state_q;
  spc_pkg::spc_state_t state_d;
  spc_pkg::spc_pins_t  pin_s;

  logic       errie_q;
  logic       mode_fault_detect_enable_q;
  logic [1:0] spr_q;
  logic [7:0] txbuf_q;
  logic       tx_full_q;
  logic [7:0] shift_q;
  logic [7:0] rxbuf_q;
  logic       receive_full_flag_q;
  logic       ovrf_q;
  logic       ovrf_arm_q;
  logic       mode_fault_flag_q;
  logic       mode_fault_flag_arm_q;
  logic [2:0] bit_q;
  logic [3:0] half_q;
  logic       sck_q;
  logic       dout_q;
  logic       sck_p_q;
  logic       ss_p_q;
  logic [7:0] rdata_q;
  logic [1:0] sck_pad_q;
  logic [1:0] mosi_pad_q;
  logic [1:0] miso_pad_q;
  logic       own_q;
  logic       ss_in_q;
  logic       ss_lvl_q;
  logic       rx_irq_q;
  logic       tx_irq_q;
  logic [3:0] sync_q;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  spc_sync #(
    .W (4)
  ) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .d    ({sck_i, mosi_i, miso_i, !ss_n_i}),
    .q    (sync_q)
  );
  // Select crosses inverted so it leaves reset at its idle high level
  assign pin_s = spc_pkg::spc_pins_t'(sync_q ^ 4'h1);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sck_p_q <= 1'b0;
      ss_p_q  <= 1'b1;
    end else begin
      sck_p_q <= pin_s.sck;
      ss_p_q  <= pin_s.ss_n;
    end
  end

  // ****************************************
  // Bus decode
  // ****************************************
  wire wr_ctl  = wr && hit(addr, `SPC_OFF_CTRL);
  wire wr_stat = wr && hit(addr, `SPC_OFF_STAT);
  wire wr_data = wr && hit(addr, `SPC_OFF_DATA);
  wire rd_stat = rd && hit(addr, `SPC_OFF_STAT);
  wire rd_data = rd && hit(addr, `SPC_OFF_DATA);

  // ****************************************
  // Mode and edge terms
  // ****************************************
  wire module_enable     = ctrl_q.module_enable;
  wire master  = module_enable && ctrl_q.mstr;
  wire slave   = module_enable && !ctrl_q.mstr;
  wire idle    = (state_q == spc_pkg::ST_IDLE);
  wire act     = (state_q == spc_pkg::ST_XFER);
  wire clock_phase    = ctrl_q.clock_phase;
  wire ss_fall = ss_p_q && !pin_s.ss_n;
  wire ss_rise = !ss_p_q && pin_s.ss_n;
  wire m_tick;

  wire s_edge  = slave && !pin_s.ss_n && (pin_s.sck != sck_p_q);
  wire s_lead  = s_edge && (pin_s.sck != ctrl_q.clock_polarity);
  wire m_run   = master && act;
  wire m_lead  = m_run && m_tick && (sck_q == ctrl_q.clock_polarity);
  wire m_trail = m_run && m_tick && (sck_q != ctrl_q.clock_polarity);
  wire lead    = s_lead || m_lead;
  wire trail   = (s_edge && !s_lead) || m_trail;

  spc_baud u_baud (
    .mclk (mclk),
    .rst  (rst),
    .run  (m_run),
    .sel  (spr_q),
    .tick (m_tick)
  );

  // ****************************************
  // Transfer control
  // ****************************************
  wire load    = module_enable && idle && tx_full_q;
  wire s_start = slave && idle &&
                 (clock_phase ? s_edge : ss_fall);
  wire start   = (master && load) || s_start;
  wire samp    = act && (clock_phase ? trail : lead);
  wire shift   = (act || s_start) && (clock_phase ? lead : trail);
  wire rx_done = samp && (bit_q == `SPC_LAST_BIT);
  wire m_end   = m_tick && m_run && (half_q == `SPC_LAST_HALF);
  wire x_end   = master ? m_end : rx_done;
  wire [7:0] src  = load ? txbuf_q : shift_q;
  wire       din  = master ? pin_s.miso : pin_s.mosi;
  wire [7:0] rx_b = {shift_q[6:0], din};

  always_comb begin
    state_d = state_q;
    if (!module_enable) begin
      state_d = spc_pkg::ST_IDLE;
    end else if (start) begin
      state_d = spc_pkg::ST_XFER;
    end else if (act && x_end) begin
      state_d = spc_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= spc_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Shifter and bit counter
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      shift_q <= 8'h00;
      bit_q   <= 3'h0;
    end else if (!module_enable) begin
      shift_q <= 8'h00;
      bit_q   <= 3'h0;
    end else if (load) begin
      shift_q <= txbuf_q;
      bit_q   <= 3'h0;
    end else if (samp) begin
      shift_q <= rx_b;
      bit_q   <= bit_q + 3'h1;
    end
  end

  // Output data bit
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dout_q <= 1'b0;
    end else if (!module_enable) begin
      dout_q <= 1'b0;
    end else if ((start && !clock_phase) || shift) begin
      dout_q <= src[7];
    end
  end

  // Master clock generator
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sck_q  <= 1'b0;
      half_q <= 4'h0;
    end else if (!m_run) begin
      sck_q  <= ctrl_q.clock_polarity;
      half_q <= 4'h0;
    end else if (m_tick) begin
      sck_q  <= !sck_q;
      half_q <= half_q + 4'h1;
    end
  end

  // ****************************************
  // Transmit buffer and empty flag
  // ****************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      txbuf_q   <= 8'h00;
      tx_full_q <= 1'b0;
    end else begin
      if (wr_data) begin
        txbuf_q <= wdata;
      end
      if (wr_data) begin
        tx_full_q <= 1'b1;
      end else if (!module_enable || load) begin
        tx_full_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Receive buffer, full and overflow flags
  // ****************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rxbuf_q <= 8'h00;
      receive_full_flag_q  <= 1'b0;
    end else if (rx_done && !receive_full_flag_q) begin
      rxbuf_q <= rx_b;
      receive_full_flag_q  <= 1'b1;
    end else if (rx_done) begin
      receive_full_flag_q  <= 1'b1;
    end else if (rd_data) begin
      receive_full_flag_q  <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ovrf_q     <= 1'b0;
      ovrf_arm_q <= 1'b0;
    end else if (rx_done && receive_full_flag_q && !rd_data) begin
      ovrf_q     <= 1'b1;
    end else if (rd_stat && ovrf_q) begin
      ovrf_arm_q <= 1'b1;
    end else if (rd_data && ovrf_arm_q) begin
      ovrf_q     <= 1'b0;
      ovrf_arm_q <= 1'b0;
    end
  end

  // ****************************************
  // Mode fault
  // ****************************************
  wire mode_fault_flag_set = mode_fault_detect_enable_q && (master ? !pin_s.ss_n
                             : (slave && act && ss_rise));

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_fault_flag_q     <= 1'b0;
      mode_fault_flag_arm_q <= 1'b0;
    end else if (mode_fault_flag_set) begin
      mode_fault_flag_q     <= 1'b1;
      mode_fault_flag_arm_q <= 1'b0;
    end else if (rd_stat && mode_fault_flag_q) begin
      mode_fault_flag_arm_q <= 1'b1;
    end else if (wr_ctl && mode_fault_flag_arm_q) begin
      mode_fault_flag_q     <= 1'b0;
      mode_fault_flag_arm_q <= 1'b0;
    end
  end

  // ****************************************
  // Control and status registers
  // ****************************************
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctl) begin
      ctrl_d = spc_pkg::spc_ctrl_t'(wdata & `SPC_CTRL_WMASK);
    end
    if (master && mode_fault_flag_set) begin
      ctrl_d.module_enable = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_q <= spc_pkg::spc_ctrl_t'(`SPC_CTRL_RST);
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      errie_q  <= 1'b0;
      mode_fault_detect_enable_q <= 1'b0;
      spr_q    <= 2'h0;
    end else if (wr_stat) begin
      errie_q  <= wdata[`SPC_ST_ERRIE];
      mode_fault_detect_enable_q <= wdata[`SPC_ST_MODE_FAULT_DETECT_ENABLE];
      spr_q    <= wdata[1:0];
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  wire [7:0] stat_v = {receive_full_flag_q, errie_q, ovrf_q, mode_fault_flag_q,
                       !tx_full_q, mode_fault_detect_enable_q, spr_q};
  wire [7:0] rd_v   = hit(addr, `SPC_OFF_CTRL) ? ctrl_q :
                      hit(addr, `SPC_OFF_STAT) ? stat_v :
                      hit(addr, `SPC_OFF_DATA) ? rxbuf_q : 8'h00;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rd ? rd_v : 8'h00;
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  wire       sck_drv  = master;
  wire       miso_drv = slave && !pin_s.ss_n;
  wire [1:0] sck_pd   = pad(sck_drv, sck_q, ctrl_q.wom);
  wire [1:0] mosi_pd  = pad(master, dout_q, ctrl_q.wom);
  wire [1:0] miso_pd  = pad(miso_drv, dout_q, ctrl_q.wom);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sck_pad_q  <= 2'h0;
      mosi_pad_q <= 2'h0;
      miso_pad_q <= 2'h0;
    end else begin
      sck_pad_q  <= sck_pd;
      mosi_pad_q <= mosi_pd;
      miso_pad_q <= miso_pd;
    end
  end

  // ****************************************
  // Port ownership and requests
  // ****************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      own_q    <= 1'b0;
      ss_in_q  <= 1'b0;
      ss_lvl_q <= 1'b1;
      rx_irq_q <= 1'b0;
      tx_irq_q <= 1'b0;
    end else begin
      own_q    <= module_enable;
      ss_in_q  <= module_enable && (!ctrl_q.mstr || mode_fault_detect_enable_q);
      ss_lvl_q <= pin_s.ss_n;
      rx_irq_q <= module_enable && ctrl_q.receive_irq_enable && receive_full_flag_q;
      tx_irq_q <= ctrl_q.transmit_irq_enable && !tx_full_q;
    end
  end

  assign rdata         = rdata_q;
  assign sck_oe        = sck_pad_q[1];
  assign sck_o         = sck_pad_q[0];
  assign mosi_oe       = mosi_pad_q[1];
  assign mosi_o        = mosi_pad_q[0];
  assign miso_oe       = miso_pad_q[1];
  assign miso_o        = miso_pad_q[0];
  assign pins_owned    = own_q;
  assign ss_input_only = ss_in_q;
  assign ss_level      = ss_lvl_q;
  assign rx_irq        = rx_irq_q;
  assign tx_irq        = tx_irq_q;

endmodule
`default_nettype wire

// File: tb/spc_core_monitor.sv
// Checker on the ports of the serial peripheral block
`include "spc_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module spc_core_monitor (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic [7:0] addr,
  input wire logic       rd,
  input wire logic       sck_oe,
  input wire logic       mosi_oe,
  input wire logic       miso_oe,
  input wire logic       ss_n_i,
  input wire logic       pins_owned,
  input wire logic       ss_input_only,
  input wire logic       ss_level,
  input wire logic       rx_irq
);
  // ****************
  // Port relations
  // ****************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  AST_MISO_QUIET: assert property (ss_level [*3] |-> !miso_oe)
    else $error("miso driven while deselected");
  AST_PINS_FREE: assert property (!pins_owned [*2] |-> !(sck_oe || mosi_oe || miso_oe))
    else $error("pin driven while disabled");
  AST_SS_GPIO: assert property (!pins_owned [*2] |-> !ss_input_only)
    else $error("select held as input while disabled");
  AST_ONE_DRIVER: assert property (!(sck_oe && miso_oe))
    else $error("clock and miso driven together");
  AST_SS_SEEN_HI: assert property (ss_n_i [*5] |-> ss_level)
    else $error("select level not high");
  AST_SS_SEEN_LO: assert property (!ss_n_i [*5] |-> !ss_level)
    else $error("select level not low");
  AST_RX_CLEAR: assert property (rd && addr == `SPC_OFF_DATA |-> ##[1:2] !rx_irq)
    else $error("receive request kept after data read");
  AST_RX_ENABLE: assert property (!pins_owned [*2] |-> !rx_irq)
    else $error("receive request while disabled");
endmodule
bind spc_core spc_core_monitor mon_u (
  .mclk, .rst, .addr, .rd, .sck_oe, .mosi_oe, .miso_oe,
  .ss_n_i, .pins_owned, .ss_input_only, .ss_level, .rx_irq
);
`default_nettype wire

// File: tb/spc_far_master.sv
// Behavioural remote master driving the link
`timescale 1ns/10ps
`default_nettype none
module spc_far_master (
  output var  logic sck,
  output var  logic mosi,
  output var  logic ss_n,
  input  wire logic miso
);
  localparam int HALF = 200;
  initial begin
    sck  = 1'b0;
    mosi = 1'b0;
    ss_n = 1'b1;
  end
  // ****************
  // One byte, MSB first; late sample absorbs pin delay
  // ****************
  task automatic xfer(input logic [7:0] tx, input logic clock_polarity, input logic clock_phase, output logic [7:0] rx);
    int i;
    sck = clock_polarity;
    #HALF;
    mosi = tx[7];
    ss_n = 1'b0;
    #(2*HALF);
    for (i = 7; i >= 0; i--) begin
      if (clock_phase) mosi = tx[i];
      sck = ~clock_polarity;
      #100;
      if (!clock_phase) rx[i] = miso;
      #(HALF-100);
      sck = clock_polarity;
      if (!clock_phase && i > 0) mosi = tx[i-1];
      #100;
      if (clock_phase) rx[i] = miso;
      #(HALF-100);
    end
    ss_n = 1'b1;
    mosi = ~mosi;
    #(2*HALF);
  endtask
  // Clock edges with select high
  task automatic clocks_only(input int n);
    repeat (2*n) begin
      sck = ~sck;
      #HALF;
    end
  endtask
  // Select pulse as another master would
  task automatic select_pulse();
    ss_n = 1'b0;
    #(2*HALF);
    ss_n = 1'b1;
    #(2*HALF);
  endtask
endmodule
`default_nettype wire

// File: tb/spi_pins_and_control_test.sv
// Self-checking bench for the serial peripheral block
`include "spc_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module spi_pins_and_control_test;
  logic       mclk, rst, wr, rd;
  logic [7:0] addr, wdata, rx;
  logic       miso_hold = 1'b0;
  wire  logic [7:0] rdata;
  wire  logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  wire  logic pins_owned, ss_input_only, ss_level, rx_irq, tx_irq;
  wire  logic sck_w, mosi_w, ss_w, miso_w;
  int         num_errors = 0;
  int         comparisons = 0;
  // Released miso shows the inverse of its last level
  always @(posedge mclk) if (miso_oe) miso_hold <= miso_o;
  assign miso_w = miso_oe ? miso_o : ~miso_hold;
  spc_core dut_u (
    .mclk, .rst, .addr, .wdata, .wr, .rd, .rdata,
    .sck_i(sck_w), .sck_o, .sck_oe, .mosi_i(mosi_w), .mosi_o, .mosi_oe,
    .miso_i(miso_w), .miso_o, .miso_oe, .ss_n_i(ss_w),
    .pins_owned, .ss_input_only, .ss_level, .rx_irq, .tx_irq
  );
  spc_far_master far_u (.sck(sck_w), .mosi(mosi_w), .ss_n(ss_w), .miso(miso_w));
  // ****************
  // Bus tasks and compare
  // ****************
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_cmp(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    cmp(rdata, e);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ****************
  // Clock, watchdog, tests
  // ****************
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    #200_000;
    num_errors++;
    close_out();
  end
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    rd_cmp(`SPC_OFF_CTRL, 8'h28);
    rd_cmp(`SPC_OFF_STAT, 8'h08);
    wr_reg(8'h13, 8'hff);
    rd_cmp(8'h13, 8'h00);
    cmp({7'h00, pins_owned}, 8'h00);
    wr_reg(`SPC_OFF_CTRL, 8'hff);
    rd_cmp(`SPC_OFF_CTRL, 8'hbf);
    #200;
    cmp({7'h00, pins_owned}, 8'h01);
    cmp({7'h00, ss_input_only}, 8'h00);
    cmp({7'h00, sck_oe}, 8'h00);
    cmp({7'h00, tx_irq}, 8'h01);
    far_u.select_pulse();
    rd_cmp(`SPC_OFF_STAT, 8'h08);
    wr_reg(`SPC_OFF_STAT, 8'h04);
    #200;
    cmp({7'h00, ss_input_only}, 8'h01);
    far_u.select_pulse();
    rd_cmp(`SPC_OFF_STAT, 8'h1c);
    rd_cmp(`SPC_OFF_CTRL, 8'hbd);
    wr_reg(`SPC_OFF_CTRL, 8'h83);
    rd_cmp(`SPC_OFF_STAT, 8'h0c);
    $display("test registers done");
    #200;
    cmp({7'h00, ss_input_only}, 8'h01);
    wr_reg(`SPC_OFF_DATA, 8'ha5);
    far_u.xfer(8'h3c, 1'b0, 1'b0, rx);
    cmp(rx, 8'ha5);
    cmp({7'h00, miso_oe}, 8'h00);
    cmp({7'h00, rx_irq}, 8'h01);
    rd_cmp(`SPC_OFF_STAT, 8'h8c);
    rd_cmp(`SPC_OFF_DATA, 8'h3c);
    rd_cmp(`SPC_OFF_STAT, 8'h0c);
    cmp({7'h00, rx_irq}, 8'h00);
    $display("test phase zero done");
    far_u.clocks_only(8);
    rd_cmp(`SPC_OFF_STAT, 8'h0c);
    wr_reg(`SPC_OFF_CTRL, 8'h9b);
    wr_reg(`SPC_OFF_DATA, 8'h5a);
    fork
      far_u.xfer(8'hc3, 1'b1, 1'b1, rx);
      begin
        #1500;
        wr_reg(`SPC_OFF_DATA, 8'h77);
      end
    join
    cmp(rx, 8'h5a);
    rd_cmp(`SPC_OFF_DATA, 8'hc3);
    far_u.xfer(8'h96, 1'b1, 1'b1, rx);
    cmp(rx, 8'h77);
    $display("test phase one done");
    wr_reg(`SPC_OFF_CTRL, 8'h99);
    #200;
    cmp({7'h00, pins_owned}, 8'h00);
    rd_cmp(`SPC_OFF_STAT, 8'h8c);
    rd_cmp(`SPC_OFF_DATA, 8'h96);
    wr_reg(`SPC_OFF_CTRL, 8'h83);
    wr_reg(`SPC_OFF_DATA, 8'h3c);
    fork
      far_u.xfer(8'h55, 1'b0, 1'b0, rx);
      begin
        #1800;
        wr_reg(`SPC_OFF_CTRL, 8'h81);
        wr_reg(`SPC_OFF_CTRL, 8'h83);
      end
    join
    rd_cmp(`SPC_OFF_STAT, 8'h0c);
    wr_reg(`SPC_OFF_DATA, 8'he1);
    far_u.xfer(8'h0f, 1'b0, 1'b0, rx);
    cmp(rx, 8'he1);
    rd_cmp(`SPC_OFF_DATA, 8'h0f);
    $display("test partial reset done");
    wr_reg(`SPC_OFF_CTRL, 8'h2a);
    #200;
    cmp({7'h00, sck_oe}, 8'h01);
    cmp({7'h00, mosi_oe}, 8'h01);
    cmp({7'h00, sck_o}, 8'h00);
    wr_reg(`SPC_OFF_DATA, 8'h81);
    #1500;
    rd_cmp(`SPC_OFF_STAT, 8'h8c);
    cmp({7'h00, sck_o}, 8'h00);
    cmp({7'h00, ss_input_only}, 8'h01);
    $display("test master done");
    close_out();
  end
endmodule
`default_nettype wire
